// File: hdl/hsm_bus_cond.sv
`timescale 1ns/1ps
module hsm_bus_cond (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_cond,
   output logic      stop_cond,
   output logic      sda_now
);

   logic scl_q;
   logic sda_q;

   // Line samples; idle bus reads high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Registered events, all one cycle late so data stays aligned
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_rise   <= 1'b0;
         scl_fall   <= 1'b0;
         start_cond <= 1'b0;
         stop_cond  <= 1'b0;
         sda_now    <= 1'b1;
      end else begin
         scl_rise   <= scl_in & ~scl_q;
         scl_fall   <= ~scl_in & scl_q;
         start_cond <= scl_in & scl_q & sda_q & ~sda_in;
         stop_cond  <= scl_in & scl_q & ~sda_q & sda_in;
         sda_now    <= sda_in;
      end
   end

endmodule : hsm_bus_cond

// File: hdl/hsm_pkg.sv
package hsm_pkg;

   // ************************************************************
   // Widths and bus constants
   // ************************************************************
   localparam int          BYTE_W        = 8;
   localparam int          CODE_W        = 12;
   localparam int          NIB_W         = 4;
   localparam int          CMD_W         = 7;
   localparam int          AEN_W         = 5;
   localparam int          HIST_W        = 4;
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam logic [1:0]  LAST_IDX      = 2'h3;
   localparam logic [6:0]  DEV_ADDR_DFLT = 7'h2a;  // Arbitrary default address

   // ************************************************************
   // Write pointer byte and extended register selects
   // ************************************************************
   localparam int          EXT_FLAG_BIT  = 7;
   localparam logic [1:0]  EXT_NONE      = 2'h0;
   localparam logic [1:0]  EXT_ALERT_EN  = 2'h1;
   localparam logic [1:0]  EXT_TRIP      = 2'h2;
   localparam logic [1:0]  EXT_CONTROL   = 2'h3;

   // ************************************************************
   // Command byte fields
   // ************************************************************
   localparam int          CMD_V_CONT    = 0;
   localparam int          CMD_V_ONCE    = 1;
   localparam int          CMD_I_CONT    = 2;
   localparam int          CMD_I_ONCE    = 3;
   localparam int          CMD_STATUS_RD = 6;
   localparam logic [6:0]  CMD_RST       = 7'h00;

   // ************************************************************
   // Alert enable, trip level and control fields
   // ************************************************************
   localparam int          AEN_SINGLE    = 0;
   localparam int          AEN_QUAD      = 1;
   localparam int          AEN_SWAP      = 2;
   localparam int          AEN_OFF       = 3;
   localparam int          AEN_CLEAR     = 4;
   localparam logic [4:0]  AEN_RST       = 5'h04;
   localparam logic [7:0]  TRIP_RST      = 8'hff;
   localparam int          CTL_SOFTWARE_POWER_OFF     = 0;

   // ************************************************************
   // Status byte fields
   // ************************************************************
   localparam int          ST_CONV_OC    = 0;
   localparam int          ST_CONV_ALERT = 1;
   localparam int          ST_ANALOG_OC  = 2;
   localparam int          ST_SWAP_FAIL  = 3;
   localparam int          ST_OFF        = 4;
   localparam int          ST_OFF_ALERT  = 5;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_ADDR      = 3'b001,
      ST_ADDR_ACK  = 3'b010,
      ST_READ      = 3'b011,
      ST_READ_ACK  = 3'b100,
      ST_WRITE     = 3'b101,
      ST_WRITE_ACK = 3'b110
   } hsm_state_t;

   typedef enum logic [1:0] {
      FMT_BOTH = 2'b00,
      FMT_VOLT = 2'b01,
      FMT_CURR = 2'b10,
      FMT_STAT = 2'b11
   } hsm_fmt_t;

endpackage : hsm_pkg

// File: hdl/hsm_readback_status.sv
`timescale 1ns/1ps
// Summary of operation
// - Eight-bit trip level, resets full scale
// - Software off bit gates output off
// - Four readback formats from command config
// - Combined read: V high, I high, nibbles
// - Voltage read: two bytes, low nibble zero
// - Current read: two bytes, low nibble zero
// - Three-byte read, ack, ack, nack, stop
// - Status read returns one acknowledged byte
// - Status bit0: last three conversions over
// - Status bit1: sticky conversion trip alert
// - Status bit2: analog overcurrent off state
// - Status bit3: sticky swap failure flag
// - Status bit4: input off or software off
// - Status bit5: sticky off alert
// - Sticky bits cleared only by clear bit
// - Pointer byte MSB one selects register
// - Status-read command returns status byte
// - Clear bit self-clears; sources may reassert
module hsm_readback_status #(
   parameter logic [6:0] DEV_ADDR      = hsm_pkg::DEV_ADDR_DFLT,
   parameter bit         RETRY_VARIANT = 1'b0
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic                        scl_in,
   input  wire logic                        sda_in,
   output logic                             sda_o,
   output logic                             sda_oe,
   input  wire logic                        power_enable_input,
   input  wire logic                        analog_overcurrent_off,
   input  wire logic                        swap_fail_event,
   input  wire logic [hsm_pkg::CODE_W-1:0]  volt_code,
   input  wire logic [hsm_pkg::CODE_W-1:0]  curr_code,
   input  wire logic                        volt_done,
   input  wire logic                        curr_done,
   output logic                             hot_swap_on,
   output logic [hsm_pkg::CMD_W-1:0]        command_bits
);

   // ************************************************************
   // Declarations
   // ************************************************************
   hsm_pkg::hsm_state_t              state;
   hsm_pkg::hsm_fmt_t                fmt;
   logic                             scl_rise, scl_fall, start_cond, stop_cond, bit_in;
   logic [2:0]                       bit_cnt;
   logic [1:0]                       byte_cnt, next_byte_cnt;
   logic                             ack_on, rd_mode, nack, wr_pulse, wr_first;
   logic [hsm_pkg::BYTE_W-1:0]       rx, tx, tx_next;
   logic [hsm_pkg::CODE_W-1:0]       volt_cap, curr_cap;
   logic [hsm_pkg::AEN_W-1:0]        alert_en;
   logic [hsm_pkg::BYTE_W-1:0]       current_trip_level;
   logic [1:0]                       ptr;
   logic                             software_power_off;
   logic [hsm_pkg::HIST_W-1:0]       hist;
   logic                             conversion_overcurrent_now, over_now, single_hit, quad_hit;
   logic                             conv_alert, swap_failure_flag, off_alert, off_prev;
   logic                             off_status, analog_overcurrent_off_bit, clear_go, addr_ok;
   logic [hsm_pkg::BYTE_W-1:0]       alert_status_byte;

   // ************************************************************
   // Bus conditions
   // ************************************************************
   hsm_bus_cond u_cond (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .start_cond (start_cond),
      .stop_cond  (stop_cond),
      .sda_now    (bit_in)
   );

   // Open drain: only ever pull low
   assign sda_o = 1'b0;

   // ************************************************************
   // Readback format and byte selection
   // ************************************************************
   // Status command overrides conversion data
   always_comb begin
      if (command_bits[hsm_pkg::CMD_STATUS_RD])
         fmt = hsm_pkg::FMT_STAT;
      else if ((command_bits[hsm_pkg::CMD_V_CONT] | command_bits[hsm_pkg::CMD_V_ONCE]) &
               ~(command_bits[hsm_pkg::CMD_I_CONT] | command_bits[hsm_pkg::CMD_I_ONCE]))
         fmt = hsm_pkg::FMT_VOLT;
      else if (~(command_bits[hsm_pkg::CMD_V_CONT] | command_bits[hsm_pkg::CMD_V_ONCE]) &
               (command_bits[hsm_pkg::CMD_I_CONT] | command_bits[hsm_pkg::CMD_I_ONCE]))
         fmt = hsm_pkg::FMT_CURR;
      else
         fmt = hsm_pkg::FMT_BOTH;
   end

   // Next byte to shift out; past the last byte the line stays released so an acked master can still stop
   always_comb begin
      tx_next = '1;
      unique case (fmt)
         hsm_pkg::FMT_BOTH: begin
            if (byte_cnt == 2'h0)
               tx_next = volt_cap[hsm_pkg::CODE_W-1:hsm_pkg::NIB_W];
            else if (byte_cnt == 2'h1)
               tx_next = curr_cap[hsm_pkg::CODE_W-1:hsm_pkg::NIB_W];
            else if (byte_cnt == 2'h2)
               tx_next = {volt_cap[hsm_pkg::NIB_W-1:0], curr_cap[hsm_pkg::NIB_W-1:0]};
         end
         hsm_pkg::FMT_VOLT: begin
            if (byte_cnt == 2'h0)
               tx_next = volt_cap[hsm_pkg::CODE_W-1:hsm_pkg::NIB_W];
            else if (byte_cnt == 2'h1)
               tx_next = {volt_cap[hsm_pkg::NIB_W-1:0], 4'h0};
         end
         hsm_pkg::FMT_CURR: begin
            if (byte_cnt == 2'h0)
               tx_next = curr_cap[hsm_pkg::CODE_W-1:hsm_pkg::NIB_W];
            else if (byte_cnt == 2'h1)
               tx_next = {curr_cap[hsm_pkg::NIB_W-1:0], 4'h0};
         end
         hsm_pkg::FMT_STAT: begin
            if (byte_cnt == 2'h0)
               tx_next = alert_status_byte;
         end
      endcase
   end

   assign next_byte_cnt = (byte_cnt == hsm_pkg::LAST_IDX) ? byte_cnt : byte_cnt + 2'h1;

   // Reads are refused while a one-shot conversion is still pending
   assign addr_ok = (rx[6:0] == DEV_ADDR) &
                    ~(bit_in & (command_bits[hsm_pkg::CMD_V_ONCE] | command_bits[hsm_pkg::CMD_I_ONCE]));

   // ************************************************************
   // Serial slave sequencer
   // ************************************************************
   // Data changes on SCL fall, sampled on SCL rise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= hsm_pkg::ST_IDLE;
         bit_cnt  <= '0;
         byte_cnt <= '0;
         ack_on   <= 1'b0;
         sda_oe   <= 1'b0;
         rx       <= '0;
         tx       <= '0;
         rd_mode  <= 1'b0;
         nack     <= 1'b0;
         wr_pulse <= 1'b0;
         wr_first <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         if (stop_cond) begin
            state  <= hsm_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            ack_on <= 1'b0;
         end else if (start_cond) begin
            state    <= hsm_pkg::ST_ADDR;
            bit_cnt  <= '0;
            byte_cnt <= '0;
            sda_oe   <= 1'b0;
            ack_on   <= 1'b0;
         end else begin
            unique case (state)
               hsm_pkg::ST_IDLE: begin
               end
               hsm_pkg::ST_ADDR: if (scl_rise) begin
                  rx      <= {rx[6:0], bit_in};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == hsm_pkg::LAST_BIT) begin
                     rd_mode <= bit_in;
                     state   <= addr_ok ? hsm_pkg::ST_ADDR_ACK : hsm_pkg::ST_IDLE;
                  end
               end
               hsm_pkg::ST_ADDR_ACK: if (scl_fall) begin
                  if (!ack_on) begin
                     ack_on <= 1'b1;
                     sda_oe <= 1'b1;
                  end else begin
                     ack_on  <= 1'b0;
                     bit_cnt <= '0;
                     if (rd_mode) begin
                        state    <= hsm_pkg::ST_READ;
                        tx       <= tx_next;
                        sda_oe   <= ~tx_next[hsm_pkg::BYTE_W-1];
                        byte_cnt <= next_byte_cnt;
                     end else begin
                        state  <= hsm_pkg::ST_WRITE;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               hsm_pkg::ST_READ: if (scl_fall) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == hsm_pkg::LAST_BIT) begin
                     state  <= hsm_pkg::ST_READ_ACK;
                     sda_oe <= 1'b0;
                  end else begin
                     tx     <= {tx[6:0], 1'b0};
                     sda_oe <= ~tx[6];
                  end
               end
               // Master ack fetches the next byte, nack ends the read
               hsm_pkg::ST_READ_ACK: begin
                  if (scl_rise)
                     nack <= bit_in;
                  else if (scl_fall) begin
                     if (nack)
                        state <= hsm_pkg::ST_IDLE;
                     else begin
                        state    <= hsm_pkg::ST_READ;
                        bit_cnt  <= '0;
                        tx       <= tx_next;
                        sda_oe   <= ~tx_next[hsm_pkg::BYTE_W-1];
                        byte_cnt <= next_byte_cnt;
                     end
                  end
               end
               hsm_pkg::ST_WRITE: if (scl_rise) begin
                  rx      <= {rx[6:0], bit_in};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == hsm_pkg::LAST_BIT) begin
                     state    <= hsm_pkg::ST_WRITE_ACK;
                     wr_pulse <= 1'b1;
                     wr_first <= (byte_cnt == 2'h0);
                     byte_cnt <= next_byte_cnt;
                  end
               end
               hsm_pkg::ST_WRITE_ACK: if (scl_fall) begin
                  if (!ack_on) begin
                     ack_on <= 1'b1;
                     sda_oe <= 1'b1;
                  end else begin
                     ack_on  <= 1'b0;
                     sda_oe  <= 1'b0;
                     bit_cnt <= '0;
                     state   <= hsm_pkg::ST_WRITE;
                  end
               end
               default: state <= hsm_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Snapshot codes at the read bit so bytes of one frame agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         volt_cap <= '0;
         curr_cap <= '0;
      end else if (state == hsm_pkg::ST_ADDR && scl_rise && bit_cnt == hsm_pkg::LAST_BIT && bit_in) begin
         volt_cap <= volt_code;
         curr_cap <= curr_code;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // First byte: command (MSB 0) or extended pointer (MSB 1)
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         command_bits       <= hsm_pkg::CMD_RST;
         alert_en           <= hsm_pkg::AEN_RST;
         current_trip_level <= hsm_pkg::TRIP_RST;
         software_power_off <= 1'b0;
         ptr                <= hsm_pkg::EXT_NONE;
      end else begin
         if (clear_go)
            alert_en[hsm_pkg::AEN_CLEAR] <= 1'b0;
         if (volt_done)
            command_bits[hsm_pkg::CMD_V_ONCE] <= 1'b0;
         if (curr_done)
            command_bits[hsm_pkg::CMD_I_ONCE] <= 1'b0;
         if (wr_pulse) begin
            if (wr_first) begin
               if (rx[hsm_pkg::EXT_FLAG_BIT])
                  ptr <= rx[1:0];
               else begin
                  command_bits <= rx[hsm_pkg::CMD_W-1:0];
                  ptr          <= hsm_pkg::EXT_NONE;
               end
            end else if (ptr == hsm_pkg::EXT_ALERT_EN)
               alert_en <= rx[hsm_pkg::AEN_W-1:0];
            else if (ptr == hsm_pkg::EXT_TRIP)
               current_trip_level <= rx;
            else if (ptr == hsm_pkg::EXT_CONTROL)
               software_power_off <= rx[hsm_pkg::CTL_SOFTWARE_POWER_OFF];
         end
      end
   end

   // ************************************************************
   // Alert detection and status
   // ************************************************************
   assign over_now   = curr_code[hsm_pkg::CODE_W-1:hsm_pkg::NIB_W] > current_trip_level;
   assign single_hit = curr_done & over_now & alert_en[hsm_pkg::AEN_SINGLE];
   assign quad_hit   = curr_done & over_now & (&hist[2:0]) & alert_en[hsm_pkg::AEN_QUAD];
   assign conversion_overcurrent_now = &hist[2:0];
   assign off_status = ~power_enable_input | software_power_off;
   assign clear_go   = alert_en[hsm_pkg::AEN_CLEAR];
   // Latching parts mirror the failure flag while swap alerts are enabled; retry parts show live state
   assign analog_overcurrent_off_bit = RETRY_VARIANT ? analog_overcurrent_off :
                                       (swap_failure_flag & alert_en[hsm_pkg::AEN_SWAP]);

   always_comb begin
      alert_status_byte = '0;
      alert_status_byte[hsm_pkg::ST_CONV_OC]    = conversion_overcurrent_now;
      alert_status_byte[hsm_pkg::ST_CONV_ALERT] = conv_alert;
      alert_status_byte[hsm_pkg::ST_ANALOG_OC]  = analog_overcurrent_off_bit;
      alert_status_byte[hsm_pkg::ST_SWAP_FAIL]  = swap_failure_flag;
      alert_status_byte[hsm_pkg::ST_OFF]        = off_status;
      alert_status_byte[hsm_pkg::ST_OFF_ALERT]  = off_alert;
   end

   // Conversion history, newest in bit 0
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         hist <= '0;
      else if (curr_done)
         hist <= {hist[2:0], over_now};
   end

   // Sticky flags; a new event beats a simultaneous clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_alert        <= 1'b0;
         swap_failure_flag <= 1'b0;
         off_alert         <= 1'b0;
         off_prev          <= 1'b1;
      end else begin
         off_prev          <= off_status;
         conv_alert        <= (conv_alert & ~clear_go) | single_hit | quad_hit;
         swap_failure_flag <= (swap_failure_flag & ~clear_go) |
                              (swap_fail_event & alert_en[hsm_pkg::AEN_SWAP]);
         off_alert         <= (off_alert & ~clear_go) |
                              (off_status & ~off_prev & alert_en[hsm_pkg::AEN_OFF]);
      end
   end

   // Same effect as dropping the enable pin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         hot_swap_on <= 1'b0;
      else
         hot_swap_on <= ~off_status;
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence ack_slot;
      state == hsm_pkg::ST_ADDR_ACK && scl_fall && !ack_on && !stop_cond && !start_cond;
   endsequence

   sequence clear_req;
      clear_go && !single_hit && !quad_hit;
   endsequence

   a_addr_ack_drive: assert property (ack_slot |=> sda_oe && state == hsm_pkg::ST_ADDR_ACK)
      else $error("address ack not driven");
   a_hot_swap_gate: assert property (hot_swap_on |-> $past(!off_status))
      else $error("output on while off requested");
   a_single_trip: assert property (single_hit |=> conv_alert)
      else $error("single trip did not raise alert");
   a_alert_sticky: assert property (conv_alert && !clear_go |=> conv_alert)
      else $error("conversion alert dropped without clear");
   a_clear_flags: assert property (clear_req |=> !conv_alert ##0 !clear_go)
      else $error("clear did not clear or self-clear");
   a_swap_fail: assert property (swap_fail_event && alert_en[hsm_pkg::AEN_SWAP] |=> swap_failure_flag)
      else $error("swap failure not flagged");
   a_off_alert: assert property ($rose(off_status) && alert_en[hsm_pkg::AEN_OFF] |=> off_alert)
      else $error("off alert not raised");
   a_three_low: assert property (curr_done && !over_now |=> !alert_status_byte[hsm_pkg::ST_CONV_OC])
      else $error("status bit0 set after low conversion");
   a_status_load: assert property (state == hsm_pkg::ST_ADDR_ACK && scl_fall && ack_on && rd_mode &&
                                   fmt == hsm_pkg::FMT_STAT && !stop_cond && !start_cond
                                   |=> tx == $past(alert_status_byte))
      else $error("status byte not loaded");
   a_off_status: assert property (!power_enable_input |-> alert_status_byte[hsm_pkg::ST_OFF])
      else $error("off status clear with input off");

endmodule : hsm_readback_status

// File: tb/hsm_i2c_master.sv
`timescale 1ns/1ps
// ************************************************************
// Serial bus master partner model
// ************************************************************
module hsm_i2c_master (
   input  wire logic core_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // Both lines released at power-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Step off the edge so the device samples settled pins
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // SDA moves 4 clocks after SCL falls, phases of 8 clocks
   task bit_io(input logic b, output logic r);
      cyc(4);
      sda_low = ~b;
      cyc(4);
      scl = 1'b1;
      cyc(8);
      r = sda;
      scl = 1'b0;
   endtask : bit_io
   task start();
      sda_low = 1'b0;
      scl = 1'b1;
      cyc(8);
      sda_low = 1'b1;
      cyc(8);
      scl = 1'b0;
   endtask : start
   // Eight bits MSB first, then the ninth slot; a_in 1 releases the line
   task xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a_out);
      for (int k = 7; k >= 0; k--) bit_io(d[k], q[k]);
      bit_io(a_in, a_out);
   endtask : xfer
   task stop();
      cyc(4);
      sda_low = 1'b1;
      cyc(4);
      scl = 1'b1;
      cyc(8);
      sda_low = 1'b0;
      cyc(8);
   endtask : stop
endmodule : hsm_i2c_master

// File: tb/test_hot_swap_monitor_readback_status.sv
`timescale 1ns/1ps
// ************************************************************
// Readback and status bench
// ************************************************************
module test_hot_swap_monitor_readback_status;
   typedef struct packed {logic [7:0] c; logic [11:0] v; logic [11:0] i; int n; logic [23:0] e;} hsm_row_t;
   logic        core_clk, rst_n, scl, m_low, pei, afo, sfe, vd, cd, sda_o, sda_oe, hs_on, a;
   logic [11:0] vc, ic;
   logic [6:0]  cmd;
   logic [7:0]  rb [3];
   int          num_errors = 0;
   int          n_checks = 0;
   hsm_row_t    rows [3] = '{'{8'h05, 12'habc, 12'h123, 3, 24'hab12c3},
                             '{8'h01, 12'h5a6, 12'h000, 2, 24'h5a6000},
                             '{8'h04, 12'h000, 12'h9e7, 2, 24'h9e7000}};
   // Pulled-up wire, low if either side pulls
   wire sda = ~(m_low | (sda_oe & ~sda_o));
   hsm_i2c_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
   hsm_readback_status uut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .power_enable_input(pei), .analog_overcurrent_off(afo), .swap_fail_event(sfe),
      .volt_code(vc), .curr_code(ic), .volt_done(vd), .curr_done(cd), .hot_swap_on(hs_on),
      .command_bits(cmd));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task chk(input logic [7:0] s, input logic [7:0] e, input string nm);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] p, input logic [7:0] d, input bit two);
      logic [7:0] q;
      m.start();
      m.xfer(8'h54, 1'b1, q, a);
      chk({7'h0, a}, 8'h00, "write ack");
      m.xfer(p, 1'b1, q, a);
      if (two) m.xfer(d, 1'b1, q, a);
      m.stop();
   endtask : wr
   // Data reads end on a no-acknowledge; the lone status byte is acknowledged
   task rd(input int n);
      m.start();
      m.xfer(8'h55, 1'b1, rb[0], a);
      chk({7'h0, a}, 8'h00, "read ack");
      for (int b = 0; b < n; b++) m.xfer(8'hff, b == n - 1 && n > 1, rb[b], a);
      m.stop();
   endtask : rd
   // Address-only frame; a high ninth bit means no acknowledge
   task probe(input logic [7:0] ad);
      m.start();
      m.xfer(ad, 1'b1, rb[0], a);
      m.stop();
   endtask : probe
   task pulse(input int n);
      repeat (n) begin
         cd = 1'b1;
         m.cyc(1);
         cd = 1'b0;
         m.cyc(3);
      end
   endtask : pulse
   task end_sim();
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      {rst_n, pei, afo, sfe, vd, cd} = 6'b010000;
      vc = 12'h000;
      ic = 12'h000;
      repeat (4) @(posedge core_clk);
      chk({1'b0, cmd}, 8'h00, "cmd reset");
      chk({7'h0, hs_on}, 8'h00, "on reset");
      #1 rst_n = 1'b1;
      m.cyc(3);
      chk({7'h0, hs_on}, 8'h01, "on");
      foreach (rows[r]) begin
         vc = rows[r].v;
         ic = rows[r].i;
         wr(rows[r].c, 8'h00, 1'b0);
         rd(rows[r].n);
         for (int b = 0; b < rows[r].n; b++) chk(rb[b], rows[r].e[23-8*b -: 8], "data");
      end
      probe(8'h56);
      chk({7'h0, a}, 8'h01, "foreign addr");
      wr(8'h81, 8'h0d, 1'b1);
      wr(8'h82, 8'h10, 1'b1);
      wr(8'h83, 8'h01, 1'b1);
      chk({7'h0, hs_on}, 8'h00, "sw off");
      ic = 12'h200;
      pulse(3);
      sfe = 1'b1;
      m.cyc(1);
      sfe = 1'b0;
      wr(8'h40, 8'h00, 1'b0);
      chk({1'b0, cmd}, 8'h40, "cmd status");
      rd(1);
      chk(rb[0], 8'h3f, "status all");
      wr(8'h83, 8'h00, 1'b1);
      ic = 12'h10f;
      pulse(3);
      rd(1);
      chk(rb[0], 8'h2e, "status sticky");
      chk({7'h0, hs_on}, 8'h01, "on again");
      wr(8'h81, 8'h1d, 1'b1);
      rd(1);
      chk(rb[0], 8'h00, "status clear");
      // Quad enable alone: three overs are not enough, the fourth trips
      wr(8'h81, 8'h02, 1'b1);
      ic = 12'h200;
      pulse(3);
      rd(1);
      chk(rb[0], 8'h01, "quad pending");
      pulse(1);
      rd(1);
      chk(rb[0], 8'h03, "quad trip");
      // One-shot voltage: reads refused until the conversion is done
      wr(8'h02, 8'h00, 1'b0);
      probe(8'h55);
      chk({7'h0, a}, 8'h01, "one-shot refuse");
      vd = 1'b1;
      m.cyc(1);
      vd = 1'b0;
      chk({1'b0, cmd}, 8'h00, "one-shot done");
      rd(3);
      chk(rb[1], 8'h20, "combined current");
      end_sim();
   end
endmodule : test_hot_swap_monitor_readback_status
